// ### window_pkg.sv
// constants and carriers for the program-memory data window
// assumes a single core clock and an 8-bit data-space bus from the core
package window_pkg;

	localparam int          DATA_AW         = 8;
	localparam int          PROG_AW         = 13;
	localparam int          PAGE_BITS       = 6;
	localparam int          BASE_BITS       = PROG_AW - PAGE_BITS;
	localparam logic [7:0]  WIN_LO_ADDR     = 8'h40;
	localparam logic [7:0]  WIN_HI_ADDR     = 8'h7F;
	localparam logic [7:0]  BASE_REG_ADDR   = 8'hC9;
	localparam logic [12:0] PROG_TOP_ADDR   = 13'h1FFF;

	// one data-space access from the core
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dbus_req_s;

	// one fetch toward program memory
	typedef struct packed {
		logic        rd;
		logic [12:0] addr;
	} prog_req_s;

endpackage

// ### prog_window.sv
// program-memory read window mapped into data space
// assumes program memory answers one cycle after a fetch request
`timescale 1ns/10ps

// Contract
// - data addresses 40h..7Fh read bytes of program memory
// - window reaches any program address 0000h..1FFFh
// - writing base moves the window in 64-byte steps
// - fetch address is base bits above the six low data-address bits
// - base register written by plain byte writes at C9h, write-only
// - base bits 6..0 hold upper address bits, bit 7 unused
// - reset leaves the base register untouched
module prog_window
	import window_pkg::*;
#(
	parameter int PROG_SIZE = 8192
)(
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             srst_i,
	// core data-space side
	input  wire dbus_req_s        dreq_i,
	output logic                  win_hit_o,
	output logic                  rvalid_o,
	output logic [7:0]            rdata_o,
	// program memory side
	output prog_req_s             preq_o,
	input  wire logic [7:0]       pdata_i
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic logic in_window(input logic [7:0] a);
		in_window = (a >= WIN_LO_ADDR) && (a <= WIN_HI_ADDR);
	endfunction

	function automatic logic is_base_addr(input logic [7:0] a);
		is_base_addr = (a == BASE_REG_ADDR);
	endfunction

	logic                 base_wr;
	logic                 win_rd;
	logic [BASE_BITS-1:0] base_r;
	logic [BASE_BITS-1:0] base_nxt;
	logic                 rvalid_r;
	logic                 rvalid_nxt;
	logic                 in_range_r;
	logic                 in_range_nxt;
	logic [PROG_AW-1:0]   fetch_addr;
	logic                 in_range;

	assign base_wr   = dreq_i.wr && is_base_addr(dreq_i.addr);
	assign win_rd    = dreq_i.rd && in_window(dreq_i.addr);
	assign win_hit_o = in_window(dreq_i.addr);

	// ------------------------------------------------------------
	// base register and fetch
	// ------------------------------------------------------------
	// reads of C9h get no answer from here: the register is write-only
	always_comb
	begin
		base_nxt = base_r;
		if (base_wr)
		begin
			base_nxt = dreq_i.wdata[BASE_BITS-1:0];
		end
	end

	// no reset term: the base keeps whatever it held across reset
	always_ff @(posedge clock_i)
	begin
		base_r <= base_nxt;
	end

	// window writes never reach program memory
	assign fetch_addr     = {base_r, dreq_i.addr[PAGE_BITS-1:0]};
	assign in_range       = 32'(fetch_addr) < PROG_SIZE;
	assign preq_o.rd      = win_rd;
	assign preq_o.addr    = fetch_addr;

	// ------------------------------------------------------------
	// read return
	// ------------------------------------------------------------
	// the byte comes straight from program memory: registering it here
	// would add a second wait cycle to every window read
	// above the fitted memory size the byte reads as zero
	always_comb
	begin
		rvalid_nxt   = win_rd;
		in_range_nxt = in_range;
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			rvalid_r   <= 1'b0;
			in_range_r <= 1'b0;
		end
		else
		begin
			rvalid_r   <= rvalid_nxt;
			in_range_r <= in_range_nxt;
		end
	end

	assign rvalid_o = rvalid_r;
	assign rdata_o  = in_range_r ? pdata_i : 8'h00;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// the base has no reset, so its hold check runs through reset as well and
	// compares by identity, which keeps a base never written from tripping it
	property p_win_fetch;
		@(posedge clock_i) disable iff (srst_i)
		(dreq_i.rd && dreq_i.addr >= WIN_LO_ADDR && dreq_i.addr <= WIN_HI_ADDR)
			|-> preq_o.rd ##1 rvalid_o;
	endproperty
	a_win_fetch: assert property (p_win_fetch) else $error("window read not fetched");

	property p_addr_form;
		@(posedge clock_i) disable iff (srst_i)
		preq_o.rd |-> preq_o.addr[PAGE_BITS-1:0] == dreq_i.addr[PAGE_BITS-1:0];
	endproperty
	a_addr_form: assert property (p_addr_form) else $error("low address bits wrong");

	property p_base_load;
		@(posedge clock_i) disable iff (srst_i)
		(dreq_i.wr && dreq_i.addr == BASE_REG_ADDR)
			|=> base_r == $past(dreq_i.wdata[BASE_BITS-1:0]);
	endproperty
	a_base_load: assert property (p_base_load) else $error("base not loaded");

	property p_base_hold;
		@(posedge clock_i)
		!(dreq_i.wr && dreq_i.addr == BASE_REG_ADDR) |=> base_r === $past(base_r);
	endproperty
	a_base_hold: assert property (p_base_hold) else $error("base changed without write");

	property p_no_write;
		@(posedge clock_i) disable iff (srst_i)
		!dreq_i.rd |-> !preq_o.rd;
	endproperty
	a_no_write: assert property (p_no_write) else $error("fetch without read");

	property p_page_step;
		@(posedge clock_i) disable iff (srst_i)
		preq_o.rd |-> preq_o.addr[PROG_AW-1:PAGE_BITS] == base_r;
	endproperty
	a_page_step: assert property (p_page_step) else $error("page bits not base");

	property p_outside;
		@(posedge clock_i) disable iff (srst_i)
		(dreq_i.addr < WIN_LO_ADDR || dreq_i.addr > WIN_HI_ADDR) |=> !rvalid_o;
	endproperty
	a_outside: assert property (p_outside) else $error("answer outside window");

	property p_bit7;
		@(posedge clock_i) disable iff (srst_i)
		(dreq_i.wr && dreq_i.addr == BASE_REG_ADDR)
			|=> base_r == $past(dreq_i.wdata) % (2 ** BASE_BITS);
	endproperty
	a_bit7: assert property (p_bit7) else $error("bit 7 leaked");

	property p_base_rd;
		@(posedge clock_i) disable iff (srst_i)
		(dreq_i.rd && is_base_addr(dreq_i.addr)) |=> !rvalid_o;
	endproperty
	a_base_rd: assert property (p_base_rd) else $error("read of base answered");

	property p_wr_quiet;
		@(posedge clock_i) disable iff (srst_i)
		(dreq_i.wr && !dreq_i.rd) |=> !rvalid_o;
	endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("write drew an answer");

	property p_reset_quiet;
		@(posedge clock_i)
		srst_i |=> !rvalid_o;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("answer after reset");

	property p_over_size;
		@(posedge clock_i) disable iff (srst_i)
		(rvalid_o && !in_range_r) |-> rdata_o == 8'h00;
	endproperty
	a_over_size: assert property (p_over_size) else $error("byte above size not zero");

	property p_in_size;
		@(posedge clock_i) disable iff (srst_i)
		(rvalid_o && in_range_r) |-> rdata_o == pdata_i;
	endproperty
	a_in_size: assert property (p_in_size) else $error("byte not from program memory");

	property p_answer_once;
		@(posedge clock_i) disable iff (srst_i)
		rvalid_o |-> $past(win_rd);
	endproperty
	a_answer_once: assert property (p_answer_once) else $error("answer without window read");

	property p_hit_decode;
		@(posedge clock_i) disable iff (srst_i)
		win_hit_o == (dreq_i.addr >= WIN_LO_ADDR && dreq_i.addr <= WIN_HI_ADDR);
	endproperty
	a_hit_decode: assert property (p_hit_decode) else $error("window hit decode wrong");

	// a read two cycles after a base write must already use the new page
	property p_base_page;
		@(posedge clock_i) disable iff (srst_i)
		base_wr ##1 !base_wr ##1 win_rd
			|-> preq_o.addr[PROG_AW-1:PAGE_BITS] == $past(dreq_i.wdata[BASE_BITS-1:0], 2);
	endproperty
	a_base_page: assert property (p_base_page) else $error("read missed the new page");

	property p_no_fetch_outside;
		@(posedge clock_i) disable iff (srst_i)
		!win_hit_o |-> !preq_o.rd;
	endproperty
	a_no_fetch_outside: assert property (p_no_fetch_outside) else $error("fetch outside window");

endmodule

// ### prog_mem_model.sv
// program memory stand-in that answers each fetch one cycle later
// assumes fetches come from the window block on the same clock
`timescale 1ns/10ps
module prog_mem_model
	import window_pkg::*;
(
	input  wire logic      clock_i,
	input  wire prog_req_s preq_i,
	output logic [7:0]     pdata_o = 8'h5A
);
	// idle cycles toggle the byte so a stale value never looks valid
	always @(posedge clock_i)
		pdata_o <= preq_i.rd ? (preq_i.addr[7:0] ^ {3'h0, preq_i.addr[12:8]}) : ~pdata_o;
endmodule

// ### program_memory_data_window_tb.sv
// self-checking bench for the program-memory data window
// assumes window_pkg and prog_mem_model are compiled first
`timescale 1ns/10ps
module program_memory_data_window_tb;
	import window_pkg::*;
	localparam int PSIZE = 4096;
	logic          clock_i;
	logic          srst_i = 1'b1;
	logic          win_hit_o;
	logic          rvalid_o;
	logic [7:0]    rdata_o;
	logic [7:0]    pdata;
	logic [7:0]    base_img;
	dbus_req_s     dreq = '0;
	prog_req_s     preq_o;
	int            n_errors = 0;
	int            checks = 0;
	int            cycles = 0;
	logic [7:0]    last_rdata;
	// each row: base byte, window address, byte expected back
	logic [23:0]   rows [5] = '{24'h004000, 24'h054140, 24'h7F7F00, 24'hBF55DA, 24'h3F6AE5};

	prog_window #(.PROG_SIZE(PSIZE)) u_dut (.clock_i(clock_i), .srst_i(srst_i),
		.dreq_i(dreq), .win_hit_o(win_hit_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
		.preq_o(preq_o), .pdata_i(pdata));
	prog_mem_model u_mem (.clock_i(clock_i), .preq_i(preq_o), .pdata_o(pdata));

	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic chk(logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one access; expectations come from the bench's own image of the base
	task automatic drive(logic rd, logic wr, logic [7:0] a, logic [7:0] d);
		logic        hit;
		logic [12:0] fa;
		hit = (a >= 8'h40) && (a <= 8'h7F);
		fa = {base_img[6:0], a[5:0]};
		@(posedge clock_i);
		// the image is updated before the register write takes effect
		if (wr && a == 8'hC9)
			base_img = d;
		dreq <= '{rd, wr, a, d};
		#1;
		chk({win_hit_o, preq_o.rd}, {hit, rd & hit});
		if (rd && hit)
			chk(preq_o.addr, fa);
		@(posedge clock_i);
		dreq <= '0;
		#1;
		chk(rvalid_o, rd & hit);
		if (rd && hit)
			chk(rdata_o, (fa >= PSIZE) ? 8'h00 : (fa[7:0] ^ {3'h0, fa[12:8]}));
		last_rdata = rdata_o;
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_errors++;
			stop_test();
		end
	end

	initial
	begin
		repeat (16) @(posedge clock_i);
		srst_i <= 1'b0;
		foreach (rows[i])
		begin
			drive(1'b0, 1'b1, 8'hC9, rows[i][23:16]);
			drive(1'b1, 1'b0, rows[i][15:8], 8'h00);
			chk(last_rdata, rows[i][7:0]);
		end
		$display("test page rows done");
		drive(1'b0, 1'b1, 8'h50, 8'hAA);
		drive(1'b1, 1'b0, 8'h50, 8'h00);
		drive(1'b1, 1'b0, 8'hC9, 8'h00);
		drive(1'b0, 1'b1, 8'hC9, 8'h85);
		drive(1'b1, 1'b0, 8'h7E, 8'h00);
		chk(last_rdata, 8'h7F);
		$display("test refusals done");
		// a window read in flight when reset arrives must not be answered
		@(posedge clock_i);
		dreq   <= '{1'b1, 1'b0, 8'h40, 8'h00};
		srst_i <= 1'b1;
		@(posedge clock_i);
		dreq   <= '0;
		#1;
		chk(rvalid_o, 1'b0);
		@(posedge clock_i);
		srst_i <= 1'b0;
		drive(1'b1, 1'b0, 8'h40, 8'h00);
		chk(last_rdata, 8'h41);
		$display("test reset keeps base done");
		stop_test();
	end
endmodule
